// ### hw/rfc_pkg.sv
// rfc_pkg: constants shared by the receiver/frame configuration block
// assumes a 100 MHz system clock and 32-bit configuration packets
package rfc_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_PACKET   = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_SEQ      = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_FRAME_LO = 8'h20;
  localparam logic [7:0] OFS_FRAME_HI = 8'h3c;

  // control and status fields
  localparam int CTRL_RUN_BIT    = 0;
  localparam int STAT_BAT_BIT    = 3;
  localparam int STAT_IGN_BIT    = 4;
  localparam int STAT_STATE_LSB  = 0;

  // sequence commands written to OFS_SEQ[2:0]
  localparam logic [2:0] CMD_OFF       = 3'h0;
  localparam logic [2:0] CMD_SYNC_SLOW = 3'h1;
  localparam logic [2:0] CMD_DATA_FAST = 3'h2;
  localparam logic [2:0] CMD_DATA_SLOW = 3'h3;
  localparam logic [2:0] CMD_SHUTDOWN  = 3'h4;

  // packet layout
  localparam logic [3:0] ON_PREFIX      = 4'h1;
  localparam logic [3:0] IDX_SYNC_SLOW  = 4'h7;
  localparam logic [3:0] IDX_DATA_FAST  = 4'h8;
  localparam logic [3:0] IDX_DATA_SLOW  = 4'h9;
  localparam logic [6:0] SHUT_PREFIX    = 7'h0d;
  localparam logic [4:0] FRAME_PREFIX   = 5'h04;
  localparam logic [7:0] CFG_ID_LO      = 8'h10;
  localparam logic [7:0] CFG_ID_HI      = 8'h1b;
  localparam int         CHECK_BIT      = 19;
  localparam int         STEP_EN_BIT    = 23;
  localparam int         LINE_LSB       = 8;
  localparam int         DUR_W          = 6;

  // reset values
  localparam logic [7:0]       LINE_RST = 8'h00;
  localparam logic [DUR_W-1:0] DUR_RST  = 6'h01;

  // frame table shape
  localparam int FRAME_GROUPS = 8;
  localparam int FRAME_WIDTH  = 16;

  // step time base
  localparam int UNIT_US          = 625;
  localparam int CLK_MHZ          = 100;
  localparam int UNIT_CYCLES      = UNIT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_OFF, ST_SYNC_SLOW, ST_DATA_FAST, ST_DATA_SLOW, ST_SHUT0, ST_SHUT1
  } rfc_state_e;

endpackage

// ### hw/rfc_frame_if.sv
// rfc_frame_if: write, word-read and frame-lookup path to the frame table
// assumes controller and table share one clock
`timescale 1ns/1ns
`default_nettype none
interface rfc_frame_if;
  logic        wrEn;
  logic [2:0]  wrGroup;
  logic [15:0] wrBits;
  logic [2:0]  rdGroup;
  logic [15:0] rdBits;
  logic [6:0]  lookFrame;
  logic        lookHit;

  modport ctl (output wrEn, wrGroup, wrBits, rdGroup, lookFrame,
               input  rdBits, lookHit);
  modport mem (input  wrEn, wrGroup, wrBits, rdGroup, lookFrame,
               output rdBits, lookHit);
endinterface
`default_nettype wire

// ### hw/rfc_frame_mem.sv
// rfc_frame_mem: 128 assigned-frame bits held as eight 16-bit groups
// assumes synchronous active-low reset; read data are registered
`timescale 1ns/1ns
`default_nettype none
module rfc_frame_mem #(
  parameter int GROUPS = rfc_pkg::FRAME_GROUPS,
  parameter int WIDTH  = rfc_pkg::FRAME_WIDTH
) (
  input  wire logic mclk,
  input  wire logic rstn,
  rfc_frame_if.mem  port
);
  import rfc_pkg::*;

  if (GROUPS != 8 || WIDTH != 16) begin : g_bad
    $error("rfc_frame_mem serves only 8 groups of 16 frames");
  end

  logic [WIDTH-1:0] words [GROUPS];

  // table storage; every bit clears at reset [R10]
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < GROUPS; i++) begin
        words[i] <= '0;
      end
    end else if (port.wrEn) begin
      words[port.wrGroup] <= port.wrBits;
    end
  end

  // word read for software, one cycle latency
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      port.rdBits <= '0;
    end else begin
      port.rdBits <= words[port.rdGroup];
    end
  end

  // frame lookup: group 0 holds frames 127..112, so group is the inverted top bits [R9]
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      port.lookHit <= 1'b0;
    end else begin
      port.lookHit <= words[~port.lookFrame[6:4]][port.lookFrame[3:0]]; // [R10]
    end
  end
endmodule
`default_nettype wire

// ### hw/rfc_receiver_frame_config.sv
// rfc_receiver_frame_config: packet decoder, receiver sequencer and frame table
// assumes an apb master on mclk; batteryLowIn is an asynchronous pin
// Function
// R1: receiver-on packet fields: index, check flag, line value
// R2: indices 7, 8, 9 select sync, fast data, slow data
// R3: sample battery input when leaving flagged state
// R4: active state's line value drives control lines
// R5: shutdown packet prefix, step bit, enable, duration
// R6: disabled step skips itself and later steps
// R7: wait duration in 625 us units per step
// R8: frame packets 32..39 carry group and sixteen bits
// R9: group zero covers frames 127 down to 112
// R10: frame assigned exactly when its bit set
// R11: host sets bits of all implied frames
// R12: host sets a frame bit before run
// R13: ignore receiver packets while run is set
// R14: ignore receiver-on packets with undefined index
`timescale 1ns/1ns
`default_nettype none
module rfc_receiver_frame_config #(
  parameter int unsigned STEP_UNIT_CYCLES = rfc_pkg::UNIT_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        batteryLowIn,
  input  wire logic [6:0]  frameSel,
  output logic             frameAssigned,
  output logic [7:0]       receiverCtrlLines,
  output logic             batteryLowSeen
);
  import rfc_pkg::*;

  if (STEP_UNIT_CYCLES < 1) begin : g_bad
    $error("STEP_UNIT_CYCLES must be at least one");
  end

  rfc_frame_if frameBus ();

  rfc_frame_mem #(
    .GROUPS (FRAME_GROUPS),
    .WIDTH  (FRAME_WIDTH)
  ) uFrameMem (
    .mclk (mclk),
    .rstn (rstn),
    .port (frameBus.mem)
  );

  // address decode, shared by the error answer and the zeroing of refused read data
  function automatic logic regHit(input logic [7:0] a);
    regHit = (a == OFS_PACKET) || (a == OFS_CTRL) || (a == OFS_SEQ) ||
             (a == OFS_STATUS) ||
             (a >= OFS_FRAME_LO && a <= OFS_FRAME_HI && a[1:0] == 2'h0);
  endfunction

  // receiver-on index to slot; slot 3 means undefined index
  function automatic logic [1:0] onSlot(input logic [3:0] idx);
    unique case (idx)
      IDX_SYNC_SLOW: onSlot = 2'h0;
      IDX_DATA_FAST: onSlot = 2'h1;
      IDX_DATA_SLOW: onSlot = 2'h2;
      default:       onSlot = 2'h3;
    endcase
  endfunction

  logic [31:0]      lastPacket;
  logic             run;
  logic             ignoredSeen;
  logic [7:0]       onLine [3];
  logic [2:0]       onCheck;
  logic [7:0]       shutLine [2];
  logic [1:0]       shutCheck;
  logic [1:0]       shutEn;
  logic [DUR_W-1:0] shutDur [2];
  rfc_state_e       state;
  rfc_state_e       next_state;
  logic [DUR_W-1:0] unitsLeft;
  logic [31:0]      preCnt;
  logic             batMeta;
  logic             batSync;
  logic [31:0]      readValue;

  // apb: a write lands only on the edge that samples pready high
  wire logic       commit   = psel & penable & pready;
  wire logic       wrCommit = commit & pwrite;
  wire logic       pktWr    = wrCommit && paddr == OFS_PACKET;
  wire logic       seqWr    = wrCommit && paddr == OFS_SEQ;
  wire logic [7:0] top      = pwdata[31:24];

  // packet classification
  wire logic       cfgLocked = run && top >= CFG_ID_LO && top <= CFG_ID_HI;   // [R13]
  wire logic [1:0] slot      = onSlot(top[3:0]);                              // [R2]
  wire logic       isOn      = top[7:4] == ON_PREFIX && slot != 2'h3;         // [R14]
  wire logic       isShut    = top[7:1] == SHUT_PREFIX;                       // [R5]
  wire logic       isFrame   = top[7:3] == FRAME_PREFIX;                      // [R8]
  wire logic       onWr      = pktWr && isOn && !cfgLocked;
  wire logic       shutWr    = pktWr && isShut && !cfgLocked;
  wire logic       frameWr   = pktWr && isFrame;

  // frame table hookup; group word goes straight in, bit 15 is the highest frame [R9]
  assign frameBus.wrEn      = frameWr;                                       // [R8]
  assign frameBus.wrGroup   = top[2:0];
  assign frameBus.wrBits    = pwdata[15:0];
  assign frameBus.rdGroup   = paddr[4:2];
  assign frameBus.lookFrame = frameSel;
  assign frameAssigned      = frameBus.lookHit;                               // [R10]

  // read mux; frame words rely on the table having read during the setup cycle
  always_comb begin
    readValue = 32'h0;
    if (paddr == OFS_PACKET) begin
      readValue = lastPacket;
    end else if (paddr == OFS_CTRL) begin
      readValue[CTRL_RUN_BIT] = run;
    end else if (paddr == OFS_SEQ || paddr == OFS_STATUS) begin
      readValue[STAT_STATE_LSB +: 3] = state;
      readValue[STAT_BAT_BIT] = batteryLowSeen;
      readValue[STAT_IGN_BIT] = ignoredSeen;
    end else if (paddr >= OFS_FRAME_LO) begin
      readValue = {16'h0, frameBus.rdBits};
    end
  end

  // apb answer: one wait cycle, then pready for exactly one cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= !regHit(paddr);
        // refused reads answer zero, even where the frame mux would match
        prdata  <= (pwrite || !regHit(paddr)) ? 32'h0 : readValue;
      end
    end
  end

  // software-written control: packet echo and run bit
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lastPacket <= 32'h0;
      run        <= 1'b0;
    end else begin
      if (pktWr) begin
        lastPacket <= pwdata;
      end
      if (wrCommit && paddr == OFS_CTRL) begin
        run <= pwdata[CTRL_RUN_BIT];
      end
    end
  end

  // receiver-on settings; undefined index leaves everything alone [R14]
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      onLine[0] <= LINE_RST;                                                  // [R4]
      onLine[1] <= LINE_RST;
      onLine[2] <= LINE_RST;
      onCheck   <= 3'h0;                                                      // [R3]
    end else if (onWr) begin
      onLine[slot]  <= pwdata[LINE_LSB +: 8];                                 // [R1]
      onCheck[slot] <= pwdata[CHECK_BIT];                                     // [R1]
    end
  end

  // shutdown step settings, step chosen by the low bit of the top byte
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shutLine[0] <= LINE_RST;
      shutLine[1] <= LINE_RST;
      shutDur[0]  <= DUR_RST;                                                 // [R7]
      shutDur[1]  <= DUR_RST;
      shutCheck   <= 2'h0;
      shutEn      <= 2'h0;                                                    // [R6]
    end else if (shutWr) begin
      shutEn[top[0]]    <= pwdata[STEP_EN_BIT];                               // [R5]
      shutCheck[top[0]] <= pwdata[CHECK_BIT];                                 // [R5]
      shutLine[top[0]]  <= pwdata[LINE_LSB +: 8];                             // [R5]
      shutDur[top[0]]   <= pwdata[DUR_W-1:0];                                 // [R5]
    end
  end

  // ignored-packet flag: set wins over a write-one clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ignoredSeen <= 1'b0;
    end else if (pktWr && !(onWr || shutWr || frameWr)) begin
      ignoredSeen <= 1'b1;                                                    // [R13] [R14]
    end else if (wrCommit && paddr == OFS_STATUS && pwdata[STAT_IGN_BIT]) begin
      ignoredSeen <= 1'b0;
    end
  end

  // battery pin crosses in through two flops before anything reads it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      batMeta <= 1'b0;
      batSync <= 1'b0;
    end else begin
      batMeta <= batteryLowIn;
      batSync <= batMeta;
    end
  end

  // line value and check flag of a state
  function automatic logic [7:0] lineFor(input rfc_state_e st);
    unique case (st)
      ST_SYNC_SLOW: lineFor = onLine[0];
      ST_DATA_FAST: lineFor = onLine[1];
      ST_DATA_SLOW: lineFor = onLine[2];
      ST_SHUT0:     lineFor = shutLine[0];
      ST_SHUT1:     lineFor = shutLine[1];
      default:      lineFor = LINE_RST;
    endcase
  endfunction

  function automatic logic checkFor(input rfc_state_e st);
    unique case (st)
      ST_SYNC_SLOW: checkFor = onCheck[0];
      ST_DATA_FAST: checkFor = onCheck[1];
      ST_DATA_SLOW: checkFor = onCheck[2];
      ST_SHUT0:     checkFor = shutCheck[0];
      ST_SHUT1:     checkFor = shutCheck[1];
      default:      checkFor = 1'b0;
    endcase
  endfunction

  wire logic unitTick = preCnt == STEP_UNIT_CYCLES - 1;
  wire logic inShut   = state == ST_SHUT0 || state == ST_SHUT1;
  wire logic stepDone = inShut && unitTick && unitsLeft <= 6'h01;             // [R7]

  // next state; a software command preempts a running shutdown
  always_comb begin
    next_state = state;
    if (seqWr) begin
      unique case (pwdata[2:0])
        CMD_OFF:       next_state = ST_OFF;
        CMD_SYNC_SLOW: next_state = ST_SYNC_SLOW;                             // [R2]
        CMD_DATA_FAST: next_state = ST_DATA_FAST;
        CMD_DATA_SLOW: next_state = ST_DATA_SLOW;
        CMD_SHUTDOWN:  next_state = shutEn[0] ? ST_SHUT0 : ST_OFF;            // [R6]
        default:       next_state = state;
      endcase
    end else if (stepDone) begin
      next_state = (state == ST_SHUT0 && shutEn[1]) ? ST_SHUT1 : ST_OFF;      // [R6]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // step timer: unit prescaler plus unit count; code zero behaves as one unit
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      preCnt    <= 32'h0;
      unitsLeft <= DUR_RST;
    end else if (next_state != state) begin
      preCnt    <= 32'h0;
      unitsLeft <= shutDur[next_state == ST_SHUT1];                           // [R7]
    end else if (inShut) begin
      preCnt <= unitTick ? 32'h0 : preCnt + 32'h1;
      if (unitTick && unitsLeft > 6'h01) begin
        unitsLeft <= unitsLeft - 6'h01;
      end
    end
  end

  // control lines follow the state being entered [R4]
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      receiverCtrlLines <= LINE_RST;
    end else begin
      receiverCtrlLines <= lineFor(next_state);                               // [R4]
    end
  end

  // battery sample taken on the way out of a flagged state; the sample wins the clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      batteryLowSeen <= 1'b0;
    end else if (next_state != state && checkFor(state)) begin
      batteryLowSeen <= batSync;                                              // [R3]
    end else if (wrCommit && paddr == OFS_STATUS && pwdata[STAT_BAT_BIT]) begin
      batteryLowSeen <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### bench/rfc_receiver_frame_config_monitor.sv
// rfc_config_monitor: concurrent checks on the config block's top-level ports
// assumes one clock mclk and synchronous active-low rstn; bound below
`timescale 1ns/1ns
`default_nettype none
module rfc_config_monitor
  import rfc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        batteryLowIn,
  input wire logic [6:0]  frameSel,
  input wire logic        frameAssigned,
  input wire logic [7:0]  receiverCtrlLines,
  input wire logic        batteryLowSeen
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // a write commits only at the edge that sees pready
  logic wrDone;
  assign wrDone = psel && penable && pwrite && pready;

  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_frame_wr;
    wrDone && paddr == OFS_PACKET && pwdata[31:27] == FRAME_PREFIX
      && frameSel[6:4] == ~pwdata[26:24] ##1 $stable(frameSel);
  endsequence

  property p_answer; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_reset_vals;
    $rose(rstn) |-> receiverCtrlLines == LINE_RST && !batteryLowSeen && !frameAssigned;
  endproperty
  property p_off_lines;
    wrDone && paddr == OFS_SEQ && pwdata[2:0] == CMD_OFF |-> ##2 receiverCtrlLines == LINE_RST;
  endproperty
  // group select counts frames downward, so the low nibble picks the bit
  property p_frame_write;
    s_frame_wr |-> ##1 frameAssigned == 1'($past(pwdata[15:0], 2) >> $past(frameSel[3:0]));
  endproperty
  property p_frame_hold;
    $past(frameSel) == $past(frameSel, 2) && !$past(wrDone, 2) |-> $stable(frameAssigned);
  endproperty
  // the pin passes two synchroniser flops before it can be seen
  property p_bat_cause;
    $rose(batteryLowSeen) |-> $past(batteryLowIn, 2) || $past(batteryLowIn, 3)
      || $past(batteryLowIn, 4);
  endproperty

  a_answer: assert property (p_answer) else $error("pready not after one wait");
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  a_err: assert property (p_err) else $error("bad error answer");
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  a_off_lines: assert property (p_off_lines) else $error("lines not off");
  a_frame_write: assert property (p_frame_write) else $error("frame bit wrong");
  a_frame_hold: assert property (p_frame_hold) else $error("frame bit moved");
  a_bat_cause: assert property (p_bat_cause) else $error("battery seen no cause");
endmodule

bind rfc_receiver_frame_config rfc_config_monitor mon (
  .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .batteryLowIn(batteryLowIn), .frameSel(frameSel), .frameAssigned(frameAssigned),
  .receiverCtrlLines(receiverCtrlLines), .batteryLowSeen(batteryLowSeen)
);
`default_nettype wire

// ### bench/rfc_host_model.sv
// rfc_host_model: host side, writes and reads words over apb
// assumes the slave answers by pready; waits have no cap, the bench watchdog ends a hang
`timescale 1ns/1ns
`default_nettype none
module rfc_host_model (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show junk so stale values are never trusted
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### bench/rfc_receiver_frame_config_tb.sv
// rfc_receiver_frame_config_tb: scenario tasks for the config block
// assumes rfc_host_model for apb and a short step unit of 4 cycles
`timescale 1ns/1ns
`default_nettype none
module rfc_receiver_frame_config_tb;
  import rfc_pkg::*;
  localparam int U = 4;
  logic        mclk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        batteryLowIn;
  logic [6:0]  frameSel;
  logic        frameAssigned;
  logic [7:0]  receiverCtrlLines;
  logic        batteryLowSeen;
  int          errors;
  int          testsRun;

  rfc_receiver_frame_config #(.STEP_UNIT_CYCLES(U)) uut (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .batteryLowIn(batteryLowIn), .frameSel(frameSel), .frameAssigned(frameAssigned),
    .receiverCtrlLines(receiverCtrlLines), .batteryLowSeen(batteryLowSeen));
  rfc_host_model host (
    .mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic seq(input logic [2:0] c);
    wr(OFS_SEQ, {29'h0, c});
    repeat (3) @(posedge mclk);
  endtask
  function automatic logic [31:0] onPkt(logic [3:0] k, logic c, logic [7:0] ln);
    return {ON_PREFIX, k, 4'h0, c, 3'h0, ln, 8'h00};
  endfunction
  function automatic logic [31:0] shutPkt(logic s, logic en, logic [7:0] ln, logic [5:0] d);
    return {SHUT_PREFIX, s, en, 7'h00, ln, 2'b00, d};
  endfunction
  // cycles that a line value stands on the control lines
  task automatic span(input logic [7:0] ln, output int n);
    int g;
    g = 0;
    n = 0;
    while (receiverCtrlLines !== ln && g < 20) begin
      @(posedge mclk);
      g++;
    end
    while (receiverCtrlLines === ln && n < 2000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic t_reset;
    logic [31:0] q;
    rd(OFS_STATUS, q);
    chk(q, 32'h0); // status clear
    chk({24'h0, receiverCtrlLines}, 32'h0); // lines clear
    for (int g = 0; g < FRAME_GROUPS; g++) begin
      rd(8'(OFS_FRAME_LO + 4 * g), q);
      chk(q, 32'h0); // frames clear
    end
  endtask
  task automatic t_frames;
    logic [31:0] q;
    logic [15:0] b;
    for (int g = 0; g < FRAME_GROUPS; g++) begin
      b = 16'h8000 | 16'(g);
      frameSel <= 7'(127 - 16 * g);
      wr(OFS_PACKET, {FRAME_PREFIX, 3'(g), 8'h00, b}); // implied frames
      repeat (2) @(posedge mclk);
      chk({31'h0, frameAssigned}, 32'h1); // top frame
      frameSel <= 7'(112 - 16 * g);
      repeat (2) @(posedge mclk);
      chk({31'h0, frameAssigned}, {31'h0, b[0]}); // bottom frame
      frameSel <= 7'(126 - 16 * g);
      repeat (2) @(posedge mclk);
      chk({31'h0, frameAssigned}, 32'h0); // clear bit
      rd(8'(OFS_FRAME_LO + 4 * g), q);
      chk(q, {16'h0, b}); // word back
    end
  endtask
  task automatic t_on;
    logic [31:0] q;
    logic [3:0]  idx [3];
    idx = '{IDX_SYNC_SLOW, IDX_DATA_FAST, IDX_DATA_SLOW};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_PACKET, onPkt(idx[i], i == 0, 8'(8'h31 + i))); // fields
      seq(3'(i + 1));
      chk({24'h0, receiverCtrlLines}, 32'(8'h31 + i)); // line value
      rd(OFS_STATUS, q);
      chk({29'h0, q[2:0]}, 32'(i + 1)); // state
    end
    wr(OFS_PACKET, onPkt(4'h6, 1'b0, 8'hee));
    rd(OFS_PACKET, q);
    chk(q, onPkt(4'h6, 1'b0, 8'hee)); // packet echo
    rd(OFS_STATUS, q);
    chk({31'h0, q[4]}, 32'h1); // undefined index
    wr(OFS_STATUS, 32'h10);
    wr(OFS_CTRL, 32'h1); // frame bits already set
    rd(OFS_CTRL, q);
    chk(q, 32'h1); // run bit reads back
    wr(OFS_PACKET, onPkt(IDX_SYNC_SLOW, 1'b0, 8'haa));
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, q);
    chk({31'h0, q[4]}, 32'h1); // dropped while running
    seq(CMD_SYNC_SLOW);
    chk({24'h0, receiverCtrlLines}, 32'h31); // kept setting
  endtask
  task automatic t_battery;
    batteryLowIn <= 1'b1;
    seq(CMD_OFF);
    repeat (3) @(posedge mclk);
    chk({31'h0, batteryLowSeen}, 32'h1); // flagged exit
    batteryLowIn <= 1'b0;
    seq(CMD_DATA_FAST);
    seq(CMD_OFF);
    repeat (3) @(posedge mclk);
    chk({31'h0, batteryLowSeen}, 32'h1); // unflagged exit
    seq(CMD_SYNC_SLOW);
    seq(CMD_OFF);
    repeat (3) @(posedge mclk);
    chk({31'h0, batteryLowSeen}, 32'h0); // new sample
  endtask
  task automatic t_shut;
    logic [31:0] q;
    int          n;
    wr(OFS_PACKET, shutPkt(1'b0, 1'b1, 8'h81, 6'h3f)); // longest step
    wr(OFS_PACKET, shutPkt(1'b1, 1'b1, 8'h82, 6'h01)); // step one
    wr(OFS_SEQ, {29'h0, CMD_SHUTDOWN});
    span(8'h81, n);
    chk(32'(n), 32'(63 * U)); // step time
    span(8'h82, n);
    chk(32'(n), 32'(U)); // second step
    chk({24'h0, receiverCtrlLines}, 32'h0); // sequence done
    wr(OFS_PACKET, shutPkt(1'b0, 1'b1, 8'h81, 6'h02));
    wr(OFS_PACKET, shutPkt(1'b1, 1'b0, 8'h82, 6'h01));
    wr(OFS_SEQ, {29'h0, CMD_SHUTDOWN});
    span(8'h81, n);
    chk(32'(n), 32'(2 * U)); // two units
    chk({24'h0, receiverCtrlLines}, 32'h0); // later step skipped
    wr(OFS_PACKET, shutPkt(1'b0, 1'b0, 8'h81, 6'h02));
    wr(OFS_PACKET, shutPkt(1'b1, 1'b1, 8'h82, 6'h01));
    seq(CMD_SYNC_SLOW);
    seq(CMD_SHUTDOWN);
    chk({24'h0, receiverCtrlLines}, 32'h0); // all steps skipped
    rd(OFS_STATUS, q);
    chk({29'h0, q[2:0]}, 32'h0); // back to off
  endtask
  task automatic t_unmapped;
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, 8'h84, 32'hffffffff, q, e);
    chk({31'h0, e}, 32'h1); // write refused
    host.xfer(1'b0, 8'h80, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1); // read refused
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    batteryLowIn = 1'b0;
    frameSel = 7'h00;
    errors = 0;
    testsRun = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_frames;
    t_on;
    t_battery;
    t_shut;
    t_unmapped;
    end_sim;
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
